/* bench/csn_nvm_model.sv */
// Purpose: nonvolatile storage model answering the copy handshake
// Assumes: same clock as the register bank; contents survive reset
// Notes: nvm_wait sets how many cycles a copy takes
`timescale 1ns/1ps
module csn_nvm_model (
    input wire logic clk_sys,
    input wire logic [3:0] nvm_wait,
    input wire logic nvm_prog_req,
    input wire logic nvm_prog_lock,
    output logic nvm_prog_done,
    output logic nvm_locked_strap
);
    logic [3:0] cnt_ff = 4'h0;
    logic locked_ff = 1'b0;
    initial nvm_prog_done = 1'b0;
    assign nvm_locked_strap = locked_ff;
    always @(posedge clk_sys) begin
        nvm_prog_done <= 1'b0;
        if (nvm_prog_req && !nvm_prog_done) begin
            if (cnt_ff >= nvm_wait) begin
                nvm_prog_done <= 1'b1;
                cnt_ff <= 4'h0;
                locked_ff <= locked_ff | nvm_prog_lock;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end else if (!nvm_prog_req) begin
            // a copy cut short by reset leaves no stale count behind
            cnt_ff <= 4'h0;
        end
    end
endmodule : csn_nvm_model

/* bench/csn_regs_monitor.sv */
// Purpose: concurrent checks on the status / nvm control register bank ports
// Assumes: bound to csn_regs, single clk_sys domain
// Notes: status checks keep clear of the async input sync delay
`timescale 1ns/1ps
module csn_regs_monitor #(
    parameter int BOOST_LIMIT_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic fault_evt,
    input wire logic nvm_prog_req,
    input wire logic nvm_prog_lock,
    input wire logic nvm_prog_done,
    input wire logic nvm_locked_status
);
    logic rd_stat;
    logic rd_ctl;
    logic wr_ctl;
    assign rd_stat = reg_rd && (reg_addr == csn_pkg::ADDR_CONVERTER_STATUS);
    assign rd_ctl = reg_rd && (reg_addr == csn_pkg::ADDR_NVM_CONTROL);
    assign wr_ctl = reg_wr && (reg_addr == csn_pkg::ADDR_NVM_CONTROL);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_ctl_low_zero: assert property (rd_ctl |=> reg_rdata[4:0] == 5'h00)
        else $error("reserved control bits not zero");
    a_ctl_lock_view: assert property (rd_ctl |=> reg_rdata[5] == $past(nvm_locked_status))
        else $error("lock status bit wrong");
    a_ctl_top_view: assert property (rd_ctl |=> reg_rdata[7] == $past(nvm_prog_req))
        else $error("trigger bit readback wrong");
    a_wen_starts_copy: assert property ($past(rst_n) && wr_ctl && reg_wdata[7] && !nvm_prog_req
        && !nvm_locked_status |=> nvm_prog_req) else $error("copy not started");
    a_trigger_self_clear: assert property (nvm_prog_req && nvm_prog_done |=> !nvm_prog_req)
        else $error("trigger not cleared");
    a_lock_applied: assert property (nvm_prog_req && nvm_prog_done && nvm_prog_lock
        |=> nvm_locked_status) else $error("lock not applied");
    a_lock_kept: assert property (nvm_locked_status |=> nvm_locked_status)
        else $error("lock released");
    a_locked_no_copy: assert property (nvm_locked_status && !nvm_prog_req |=> !nvm_prog_req)
        else $error("copy started while locked");
    a_lock_req_bit: assert property (wr_ctl && reg_wdata[6] |=> nvm_prog_lock)
        else $error("lock request not stored");
    a_fault_read_clear: assert property ((!fault_evt)[*6] ##0 rd_stat ##1 rd_stat
        |=> !reg_rdata[1]) else $error("fault flag not cleared by read");

    c_status_read: cover property (rd_stat);
    c_lock_done: cover property (nvm_prog_done && nvm_prog_lock);
    c_wen_refused: cover property (nvm_locked_status && wr_ctl && reg_wdata[7]);
endmodule : csn_regs_monitor

/* bench/csn_regs_tb_top.sv */
// Purpose: self-checking bench for the status / nvm control register bank
// Assumes: register port taken on rising clk_sys, read data one cycle later
// Notes: boost limit count shortened to 8 cycles
`timescale 1ns/1ps
module csn_regs_tb_top;
    localparam int BOOST_LIMIT_CYCLES = 8;
    logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, thermal_shutdown_evt, die_over_temp;
    logic pfm_active, boost_running, bypass_limit_evt, avg_input_limit, fault_evt;
    logic output_in_window, forced_pass_through, nvm_locked_strap, nvm_prog_req;
    logic nvm_prog_lock, nvm_prog_done, nvm_locked_status;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [8:0] cond;
    logic [3:0] nvm_wait;
    int fails = 0;
    int checks_done = 0;
    assign {forced_pass_through, thermal_shutdown_evt, die_over_temp, pfm_active, boost_running,
        bypass_limit_evt, avg_input_limit, fault_evt, output_in_window} = cond;

    csn_regs #(.BOOST_LIMIT_CYCLES(BOOST_LIMIT_CYCLES)) dut (.*);
    csn_nvm_model u_nvm (.*);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    // strobes drop here, and rd drops reg_wr and wr drops reg_rd, so back-to-back reads hold reg_rd high without a gap
    task automatic cyc(input int n);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        chk8((reg_rvalid === 1'b1) ? reg_rdata : 8'hXX, e);
    endtask : rd

    task automatic apply(input logic [8:0] c, input logic [7:0] e);
        cond = c;
        cyc(5);
        rd(8'h05, e);
    endtask : apply

    task automatic wait_idle();
        int i;
        cyc(1);
        for (i = 0; i < 50 && nvm_prog_req !== 1'b0; i++) begin
            cyc(1);
        end
        if (i == 50) begin
            fails++;
            $display("BAD t=%0t nvm copy never ended", $time);
            stop_test();
        end
    endtask : wait_idle

    task automatic do_reset();
        rst_n = 1'b0;
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
    endtask : do_reset

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cond = 9'h000;
        nvm_wait = 4'h0;
        do_reset();
        rd(8'h05, 8'h00);
        rd(8'hFF, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(8'hFF, 8'h3F);
        rd(8'hFF, 8'h00);
        apply(9'h070, 8'h70);
        apply(9'h001, 8'h01);
        apply(9'h100, 8'h01);
        apply(9'h000, 8'h00);
        apply(9'h08A, 8'h8A);
        apply(9'h000, 8'h8A);
        rd(8'h05, 8'h00);
        apply(9'h014, 8'h10);
        // window edge: limit seen 8 cycles only after the read two cycles later
        cyc(3);
        rd(8'h05, 8'h10);
        rd(8'h05, 8'h10);
        rd(8'h05, 8'h14);
        cyc(12);
        rd(8'h05, 8'h14);
        apply(9'h004, 8'h04);
        cyc(12);
        rd(8'h05, 8'h00);
        wr(8'hFF, 8'h80);
        rd(8'hFF, 8'h80);
        wait_idle();
        rd(8'hFF, 8'h00);
        nvm_wait = 4'hC;
        wr(8'hFF, 8'hC0);
        rd(8'hFF, 8'hC0);
        wait_idle();
        rd(8'hFF, 8'h60);
        wr(8'hFF, 8'hC0);
        rd(8'hFF, 8'h60);
        do_reset();
        rd(8'hFF, 8'h20);
        cyc(2);
        stop_test();
    end
endmodule : csn_regs_tb_top

bind csn_regs csn_regs_monitor #(.BOOST_LIMIT_CYCLES(BOOST_LIMIT_CYCLES)) u_mon (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .fault_evt(fault_evt),
    .nvm_prog_req(nvm_prog_req),
    .nvm_prog_lock(nvm_prog_lock),
    .nvm_prog_done(nvm_prog_done),
    .nvm_locked_status(nvm_locked_status)
);

/* common/csn_pkg.sv */
// Purpose: constants shared by the converter status / nvm control register bank
// Assumes: 50 MHz core clock, 8-bit register offsets from the serial slave front end
// Notes: all offsets, bit positions, reset values and timing counts live here
package csn_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CONVERTER_STATUS = 8'h05;
    localparam logic [7:0] ADDR_NVM_CONTROL = 8'hFF;
    localparam logic [7:0] RST_CONVERTER_STATUS = 8'h00;
    localparam logic [7:0] RST_NVM_CONTROL = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ****************************************
    // converter_status fields
    // ****************************************
    localparam int BIT_THERMAL_SHUTDOWN = 7;
    localparam int BIT_DIE_OVER_TEMP = 6;
    localparam int BIT_CONVERSION_SCHEME = 5;
    localparam int BIT_POWER_PATH = 4;
    localparam int BIT_BYPASS_LIMIT = 3;
    localparam int BIT_BOOST_LIMIT = 2;
    localparam int BIT_FAULT = 1;
    localparam int BIT_OUTPUT_IN_REGULATION = 0;

    // ****************************************
    // nvm_control fields
    // ****************************************
    localparam int BIT_NVM_WRITE_EN = 7;
    localparam int BIT_NVM_LOCK_REQ = 6;
    localparam int BIT_NVM_LOCKED = 5;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int BOOST_LIMIT_TIME_NS = 1500000;
    // least time: round up to whole cycles
    localparam int BOOST_LIMIT_CYCLES = (BOOST_LIMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOST_CNT_W = 17;
endpackage : csn_pkg

/* hw/csn_flag_cell.sv */
// Purpose: one sticky status flag, set by an event and cleared by a status read
// Assumes: clear is a one-cycle pulse on clk_sys
// Notes: SYNC=1 passes the event through two flip-flops first
`timescale 1ns/1ps
module csn_flag_cell #(
    parameter bit SYNC = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic clear,
    output logic flag
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic s1;
        logic s2;
        logic flag;
    } csn_cell_t;

    csn_cell_t state_ff;
    csn_cell_t nxt_state;
    logic evt;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = event_in;
        nxt_state.s2 = state_ff.s1;
        evt = SYNC ? state_ff.s2 : event_in;
        // set wins over a clear in the same cycle
        if (evt) begin
            nxt_state.flag = 1'b1;
        end else if (clear) begin
            nxt_state.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flag = state_ff.flag;
endmodule : csn_flag_cell

/* hw/csn_regs.sv */
// Purpose: converter status register and nvm control register with nvm program sequencing
// Assumes: register port comes from the serial slave front end on clk_sys;
//          analog condition inputs are asynchronous; nvm handshake is on clk_sys
// Notes: read data is registered and appears one cycle after reg_rd
//
// How it works
// - thermal shutdown sets bit 7, held until status read clears it.
// - bit 6 follows present die temperature above 115 degrees, unlatched.
// - bit 5 is 1 in pulse-frequency operation, 0 in pulse-width.
// - bit 4 is 0 in pass-through, 1 while boost runs.
// - bypass switch current limit latches bit 3 until status read.
// - bit 2 latches after average input limit held 1.5ms in boost.
// - any fault latches bit 1 until status register read.
// - bit 0 high while output is inside regulation window.
// - bit 0 forced high when forced into pass-through operation.
// - writing 1 to control bit 7 starts copy into nvm storage.
// - trigger bit 7 clears itself when the copy completes.
// - control bit 6 locks nvm after next write sequence; later writes void.
// - lock is permanent; nothing unlocks it.
// - control bit 5 reads back the nvm lock state, read-only.
// - control bits 4..0 ignore writes and read as 0.
`timescale 1ns/1ps
module csn_regs #(
    parameter int BOOST_LIMIT_CYCLES = csn_pkg::BOOST_LIMIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic thermal_shutdown_evt,
    input wire logic die_over_temp,
    input wire logic pfm_active,
    input wire logic boost_running,
    input wire logic bypass_limit_evt,
    input wire logic avg_input_limit,
    input wire logic fault_evt,
    input wire logic output_in_window,
    input wire logic forced_pass_through,
    input wire logic nvm_locked_strap,
    output logic nvm_prog_req,
    output logic nvm_prog_lock,
    input wire logic nvm_prog_done,
    output logic nvm_locked_status
);
    // ****************************************
    // state
    // ****************************************
    // level index: 0 die hot, 1 pfm, 2 boost, 3 avg limit, 4 in window, 5 forced pt
    typedef struct packed {
        logic [5:0] lvl_s1;
        logic [5:0] lvl_s2;
        logic [csn_pkg::BOOST_CNT_W-1:0] bst_cnt;
        logic bst_hit;
        logic boot_done;
        logic wen;
        logic wp;
        logic locked;
        logic prog_req;
        logic [7:0] rdata;
        logic rvalid;
    } csn_regs_t;

    csn_regs_t state_ff;
    csn_regs_t nxt_state;

    logic status_clear;
    logic thermal_shutdown_flag;
    logic bypass_limit_flag;
    logic boost_limit_flag;
    logic fault_flag;
    logic die_over_temp_flag;
    logic conversion_scheme_flag;
    logic power_path_flag;
    logic output_in_regulation_flag;
    logic [7:0] status_val;
    logic [7:0] ctrl_val;

    localparam logic [csn_pkg::BOOST_CNT_W-1:0] BST_MAX =
        csn_pkg::BOOST_CNT_W'(BOOST_LIMIT_CYCLES - 1);

    // ****************************************
    // latched status flags
    // ****************************************
    assign status_clear = reg_rd && (reg_addr == csn_pkg::ADDR_CONVERTER_STATUS);

    csn_flag_cell #(.SYNC(1'b1)) u_tsd (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(thermal_shutdown_evt),
        .clear(status_clear),
        .flag(thermal_shutdown_flag)
    );

    csn_flag_cell #(.SYNC(1'b1)) u_bypass (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(bypass_limit_evt),
        .clear(status_clear),
        .flag(bypass_limit_flag)
    );

    csn_flag_cell #(.SYNC(1'b0)) u_boost (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(state_ff.bst_hit),
        .clear(status_clear),
        .flag(boost_limit_flag)
    );

    csn_flag_cell #(.SYNC(1'b1)) u_fault (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(fault_evt),
        .clear(status_clear),
        .flag(fault_flag)
    );

    // ****************************************
    // live status bits and register images
    // ****************************************
    always_comb begin
        die_over_temp_flag = state_ff.lvl_s2[0];
        conversion_scheme_flag = state_ff.lvl_s2[1];
        power_path_flag = state_ff.lvl_s2[2];
        output_in_regulation_flag = state_ff.lvl_s2[4] || state_ff.lvl_s2[5];
        status_val = csn_pkg::RST_CONVERTER_STATUS;
        status_val[csn_pkg::BIT_THERMAL_SHUTDOWN] = thermal_shutdown_flag;
        status_val[csn_pkg::BIT_DIE_OVER_TEMP] = die_over_temp_flag;
        status_val[csn_pkg::BIT_CONVERSION_SCHEME] = conversion_scheme_flag;
        status_val[csn_pkg::BIT_POWER_PATH] = power_path_flag;
        status_val[csn_pkg::BIT_BYPASS_LIMIT] = bypass_limit_flag;
        status_val[csn_pkg::BIT_BOOST_LIMIT] = boost_limit_flag;
        status_val[csn_pkg::BIT_FAULT] = fault_flag;
        status_val[csn_pkg::BIT_OUTPUT_IN_REGULATION] = output_in_regulation_flag;
        // low bits stay at zero whatever was written
        ctrl_val = csn_pkg::RST_NVM_CONTROL;
        ctrl_val[csn_pkg::BIT_NVM_WRITE_EN] = state_ff.wen;
        ctrl_val[csn_pkg::BIT_NVM_LOCK_REQ] = state_ff.wp;
        ctrl_val[csn_pkg::BIT_NVM_LOCKED] = state_ff.locked;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.lvl_s1 = {forced_pass_through, output_in_window, avg_input_limit,
                            boost_running, pfm_active, die_over_temp};
        nxt_state.lvl_s2 = state_ff.lvl_s1;

        // average limit must hold continuously in boost for the full window
        nxt_state.bst_hit = 1'b0;
        if (state_ff.lvl_s2[3] && state_ff.lvl_s2[2]) begin
            if (state_ff.bst_cnt == BST_MAX) begin
                nxt_state.bst_hit = 1'b1;
            end else begin
                nxt_state.bst_cnt = state_ff.bst_cnt + 1'b1;
            end
        end else begin
            nxt_state.bst_cnt = '0;
        end

        // lock state held in nvm is picked up once after reset release
        if (!state_ff.boot_done) begin
            nxt_state.boot_done = 1'b1;
            nxt_state.locked = state_ff.locked || nvm_locked_strap;
        end

        // register writes
        if (reg_wr && (reg_addr == csn_pkg::ADDR_NVM_CONTROL)) begin
            nxt_state.wp = reg_wdata[csn_pkg::BIT_NVM_LOCK_REQ];
            // a new sequence starts only when idle and unlocked
            if (reg_wdata[csn_pkg::BIT_NVM_WRITE_EN] && !state_ff.prog_req
                && !state_ff.locked && state_ff.boot_done) begin
                nxt_state.wen = 1'b1;
                nxt_state.prog_req = 1'b1;
            end
        end

        // end of copy sequence
        if (state_ff.prog_req && nvm_prog_done) begin
            nxt_state.prog_req = 1'b0;
            nxt_state.wen = 1'b0;
            if (state_ff.wp) begin
                nxt_state.locked = 1'b1;
            end
        end

        // read data path
        nxt_state.rvalid = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                csn_pkg::ADDR_CONVERTER_STATUS: nxt_state.rdata = status_val;
                csn_pkg::ADDR_NVM_CONTROL: nxt_state.rdata = ctrl_val;
                default: nxt_state.rdata = csn_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = state_ff.rdata;
    assign reg_rvalid = state_ff.rvalid;
    assign nvm_prog_req = state_ff.prog_req;
    assign nvm_prog_lock = state_ff.wp;
    assign nvm_locked_status = state_ff.locked;
endmodule : csn_regs
